// ---- rtl/dcc_pkg.sv ----
// Shared constants, types and helpers of the DMA channel control block
package dcc_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NCH   = 4;
  localparam int CNT_W = 14;

  // ------------------------------------------------------------
  // Register map (byte offsets)
  // ------------------------------------------------------------
  // Per-channel window, 32 bytes each, channel in address bits 6:5
  localparam logic [4:0] OFS_CON  = 5'h00;
  localparam logic [4:0] OFS_REQ  = 5'h04;
  localparam logic [4:0] OFS_STAL = 5'h08;
  localparam logic [4:0] OFS_STAH = 5'h0c;
  localparam logic [4:0] OFS_STBL = 5'h10;
  localparam logic [4:0] OFS_STBH = 5'h14;
  localparam logic [4:0] OFS_PAD  = 5'h18;
  localparam logic [4:0] OFS_CNT  = 5'h1c;
  // Shared registers
  localparam logic [7:0] OFS_PWC    = 8'h80;
  localparam logic [7:0] OFS_RQC    = 8'h84;
  localparam logic [7:0] OFS_PPS    = 8'h88;
  localparam logic [7:0] OFS_LCA    = 8'h8c;
  localparam logic [7:0] OFS_ADRL   = 8'h90;
  localparam logic [7:0] OFS_ADRH   = 8'h94;
  localparam logic [7:0] OFS_ISTAT  = 8'h98;
  localparam logic [7:0] OFS_IMASK  = 8'h9c;
  localparam logic [7:0] OFS_MANUAL = 8'ha0;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int CON_ON     = 15;
  localparam int CON_SIZE   = 14;
  localparam int CON_DIR    = 13;
  localparam int CON_HALF   = 12;
  localparam int CON_NULL_PERIPHERAL_WRITE  = 11;
  localparam int CON_AM_LSB = 4;
  localparam int CON_MD_LSB = 0;
  localparam logic [15:0] CON_IMPL = 16'hf833;
  localparam logic [15:0] REQ_IMPL = 16'h00ff;
  localparam logic [1:0]  AM_POSTINC = 2'h0;
  localparam logic [1:0]  AM_NOINC   = 2'h1;
  localparam logic [1:0]  AM_PIA     = 2'h2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0]      RST_16  = 16'h0000;
  localparam logic [31:0]      RST_32  = 32'h0000_0000;
  localparam logic [CNT_W-1:0] RST_CNT = 14'h0000;
  localparam logic [3:0]       RST_LCA = 4'hf;

  typedef enum {ST_IDLE, ST_BUSY} dcc_state_t;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
               sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  function automatic logic [31:0] ram_addr(input logic [31:0]      start,
                                           input logic [CNT_W-1:0] idx,
                                           input logic             by_byte,
                                           input logic [1:0]       addressing_kind);
    if (addressing_kind == AM_POSTINC) begin
      ram_addr = by_byte ? start + {18'h0, idx} : start + {17'h0, idx, 1'b0};
    end else begin
      ram_addr = start;
    end
  endfunction

endpackage

// ---- rtl/dcc_arb_if.sv ----
// Request and grant bundle between the sequencer and the channel arbiter
`timescale 1ns/10ps
`default_nettype none
interface dcc_arb_if;
  logic [3:0] req;
  logic       gnt_valid;
  logic [1:0] gnt_ch;
  modport arb  (input req, output gnt_valid, output gnt_ch);
  modport user (output req, input gnt_valid, input gnt_ch);
endinterface
`default_nettype wire

// ---- rtl/dcc_arbiter.sv ----
// Fixed-priority channel arbiter, lowest channel number wins
`timescale 1ns/10ps
`default_nettype none
module dcc_arbiter (
  dcc_arb_if.arb bus
);
  always_comb begin
    bus.gnt_valid = |bus.req;
    bus.gnt_ch    = 2'h0;
    // Scan downward so the lowest pending channel is kept
    for (int c = 3; c >= 0; c--) begin
      if (bus.req[c]) begin
        bus.gnt_ch = 2'(c); // [R13]
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dcc_top.sv ----
// Four-channel DMA control: registers, request logic and transfer sequencer
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Contract
// R01: Four channels, each with own registers
// R02: Control, select, two starts, peripheral, count
// R03: Shared collision, ping-pong, channel, address status
// R04: Completion flag kept outside; only events leave; code also latches completion flags in ISTAT and drives a level IRQ
// R05: Enable bit 15 gates request response
// R06: Bit 14 selects byte or word
// R07: Bit 13 selects transfer direction
// R08: Bit 12 selects half or full interrupt
// R09: Bit 11 adds null peripheral write
// R10: Bits 5-4 select addressing kind
// R11: Bits 1-0 select continuous/one-shot, ping-pong
// R12: Unimplemented control bits read zero
// R13: Lowest channel number wins arbitration
// R14: Ping-pong alternates start address per block
// R15: Request source select or manual start
// R16: Block completion raises channel event
// R17: Control fields reset to zero
// R18: Block ends after programmed count; one-shot stops
// ------------------------------------------------------------
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  input  wire logic        REQ_STROBE,
  input  wire logic [7:0]  REQ_SOURCE,
  output var  logic        XFER_VALID,
  output var  logic [1:0]  XFER_CHANNEL,
  output var  logic [31:0] XFER_RAM_ADDR,
  output var  logic [15:0] XFER_PERIPH_ADDR,
  output var  logic        XFER_RAM_TO_PERIPH,
  output var  logic        XFER_BYTE,
  output var  logic        XFER_NULL_WRITE,
  output var  logic        XFER_PERIPH_INDIRECT,
  input  wire logic        XFER_DONE,
  input  wire logic        XFER_WCOL,
  output var  logic [3:0]  CH_IRQ,
  output var  logic        IRQ
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [15:0]      con_reg    [NCH];
  logic [15:0]      reqsel_reg [NCH];
  logic [31:0]      sta_reg    [NCH];
  logic [31:0]      stb_reg    [NCH];
  logic [15:0]      pad_reg    [NCH];
  logic [CNT_W-1:0] cnt_reg    [NCH];
  logic [CNT_W-1:0] idx_reg    [NCH];
  logic [3:0]       pend_reg;
  logic [3:0]       ppst_reg;
  logic [3:0]       pwc_reg;
  logic [3:0]       rqc_reg;
  logic [3:0]       lca_reg;
  logic [31:0]      ladr_reg;
  logic [7:0]       istat_reg;
  logic [7:0]       imask_reg;
  dcc_state_t       state_reg;
  logic [1:0]       cur_reg;

  logic             wr_stb;
  logic             rd_stb;
  logic [7:0]       a;
  logic             in_ch;
  logic [1:0]       wch;
  logic [4:0]       off;
  logic [31:0]      rdv;
  logic [3:0]       on_vec;
  logic [3:0]       arm;
  logic [3:0]       set_req;
  logic [3:0]       clr_req;
  logic [3:0]       chan_ev;
  logic             done_ev;
  logic             blk_last;
  logic             half_pt;
  logic             stop_ev;
  logic [15:0]      ccur;

  dcc_arb_if arb ();

  dcc_arbiter u_arb (
    .bus (arb)
  );

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Single-wait-state slave: request taken while ack is low
  assign wr_stb = CLK_EN & WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
  assign rd_stb = CLK_EN & WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O;
  assign a      = {WB_ADR_I[7:2], 2'h0};
  assign in_ch  = ~a[7];
  assign wch    = a[6:5];
  assign off    = a[4:0];

  always_comb begin
    rdv = RST_32;
    if (in_ch) begin
      unique case (off)
        OFS_CON:  rdv = {16'h0, con_reg[wch]}; // [R12]
        OFS_REQ:  rdv = {16'h0, reqsel_reg[wch]};
        OFS_STAL: rdv = {16'h0, sta_reg[wch][15:0]};
        OFS_STAH: rdv = {16'h0, sta_reg[wch][31:16]};
        OFS_STBL: rdv = {16'h0, stb_reg[wch][15:0]};
        OFS_STBH: rdv = {16'h0, stb_reg[wch][31:16]};
        OFS_PAD:  rdv = {16'h0, pad_reg[wch]};
        OFS_CNT:  rdv = {18'h0, cnt_reg[wch]};
        default:  rdv = RST_32;
      endcase
    end else begin
      case (a)
        OFS_PWC:   rdv = {28'h0, pwc_reg}; // [R03]
        OFS_RQC:   rdv = {28'h0, rqc_reg};
        OFS_PPS:   rdv = {28'h0, ppst_reg};
        OFS_LCA:   rdv = {28'h0, lca_reg};
        OFS_ADRL:  rdv = {16'h0, ladr_reg[15:0]};
        OFS_ADRH:  rdv = {16'h0, ladr_reg[31:16]};
        OFS_ISTAT: rdv = {24'h0, istat_reg};
        OFS_IMASK: rdv = {24'h0, imask_reg};
        default:   rdv = RST_32;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= RST_32;
    end else if (CLK_EN) begin
      WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
      if (rd_stb) begin
        WB_DAT_O <= rdv;
      end
    end
  end

  // ------------------------------------------------------------
  // Channel configuration
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      for (int c = 0; c < NCH; c++) begin
        con_reg[c]    <= RST_16; // [R17]
        reqsel_reg[c] <= RST_16;
        sta_reg[c]    <= RST_32;
        stb_reg[c]    <= RST_32;
        pad_reg[c]    <= RST_16;
        cnt_reg[c]    <= RST_CNT;
      end
    end else if (CLK_EN) begin
      // Each channel owns its copy; the window picks which [R01] [R02]
      if (wr_stb && in_ch) begin
        unique case (off)
          OFS_CON: con_reg[wch] <= merge16(con_reg[wch], WB_DAT_I[15:0],
                                           WB_SEL_I[1:0]) & CON_IMPL; // [R12]
          OFS_REQ: reqsel_reg[wch] <= merge16(reqsel_reg[wch], WB_DAT_I[15:0],
                                              WB_SEL_I[1:0]) & REQ_IMPL; // [R15]
          OFS_STAL: sta_reg[wch][15:0] <= merge16(sta_reg[wch][15:0],
                                                  WB_DAT_I[15:0], WB_SEL_I[1:0]);
          OFS_STAH: sta_reg[wch][31:16] <= merge16(sta_reg[wch][31:16],
                                                   WB_DAT_I[15:0], WB_SEL_I[1:0]);
          OFS_STBL: stb_reg[wch][15:0] <= merge16(stb_reg[wch][15:0],
                                                  WB_DAT_I[15:0], WB_SEL_I[1:0]);
          OFS_STBH: stb_reg[wch][31:16] <= merge16(stb_reg[wch][31:16],
                                                   WB_DAT_I[15:0], WB_SEL_I[1:0]);
          OFS_PAD: pad_reg[wch] <= merge16(pad_reg[wch], WB_DAT_I[15:0],
                                           WB_SEL_I[1:0]);
          OFS_CNT: cnt_reg[wch] <= CNT_W'(merge16({2'h0, cnt_reg[wch]},
                                                  WB_DAT_I[15:0], WB_SEL_I[1:0]));
          default: ;
        endcase
      end
      // One-shot end drops the enable; hardware wins over a racing write
      if (stop_ev) begin
        con_reg[cur_reg][CON_ON] <= 1'b0; // [R18]
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      on_vec[c] = con_reg[c][CON_ON];
      // Fresh enable restarts the block at buffer A
      arm[c] = wr_stb && in_ch && off == OFS_CON && wch == 2'(c) &&
               !con_reg[c][CON_ON] &&
               WB_SEL_I[1] && WB_DAT_I[CON_ON];
    end
  end

  // ------------------------------------------------------------
  // Request capture and arbitration
  // ------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      set_req[c] = on_vec[c] && // [R05]
                   ((REQ_STROBE && REQ_SOURCE == reqsel_reg[c][7:0]) ||
                    (wr_stb && a == OFS_MANUAL && WB_SEL_I[0] && WB_DAT_I[c])); // [R15]
      clr_req[c] = state_reg == ST_IDLE && arb.gnt_valid && arb.gnt_ch == 2'(c);
    end
  end

  assign arb.req = pend_reg & on_vec; // [R13]

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pend_reg <= 4'h0;
      rqc_reg  <= 4'h0;
    end else if (CLK_EN) begin
      // A new request beats the grant-side clear
      pend_reg <= ((pend_reg & ~clr_req) | set_req) & on_vec; // [R13]
      if (wr_stb && a == OFS_RQC && WB_SEL_I[0]) begin
        rqc_reg <= (rqc_reg & ~WB_DAT_I[3:0]) | (set_req & pend_reg & ~clr_req);
      end else begin
        rqc_reg <= rqc_reg | (set_req & pend_reg & ~clr_req); // [R03]
      end
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  assign ccur     = con_reg[cur_reg];
  assign done_ev  = CLK_EN && state_reg == ST_BUSY && XFER_DONE;
  assign blk_last = idx_reg[cur_reg] == cnt_reg[cur_reg]; // [R18]
  assign half_pt  = idx_reg[cur_reg] == (cnt_reg[cur_reg] >> 1);
  // One-shot stops at block end; with ping-pong only after buffer B
  assign stop_ev  = done_ev && blk_last && ccur[CON_MD_LSB] &&
                    (!ccur[CON_MD_LSB+1] || ppst_reg[cur_reg]); // [R11] [R18]

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chan_ev[c] = done_ev && cur_reg == 2'(c) &&
                   (ccur[CON_HALF] ? half_pt : blk_last); // [R08] [R16]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_reg            <= ST_IDLE;
      cur_reg              <= 2'h0;
      ppst_reg             <= 4'h0;
      lca_reg              <= RST_LCA;
      ladr_reg             <= RST_32;
      XFER_VALID           <= 1'b0;
      XFER_CHANNEL         <= 2'h0;
      XFER_RAM_ADDR        <= RST_32;
      XFER_PERIPH_ADDR     <= RST_16;
      XFER_RAM_TO_PERIPH   <= 1'b0;
      XFER_BYTE            <= 1'b0;
      XFER_NULL_WRITE      <= 1'b0;
      XFER_PERIPH_INDIRECT <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        idx_reg[c] <= RST_CNT;
      end
    end else if (CLK_EN) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (arb.gnt_valid) begin
            cur_reg          <= arb.gnt_ch;
            XFER_VALID       <= 1'b1;
            XFER_CHANNEL     <= arb.gnt_ch;
            XFER_RAM_ADDR    <= ram_addr(ppst_reg[arb.gnt_ch] ?
                                         stb_reg[arb.gnt_ch] :
                                         sta_reg[arb.gnt_ch], // [R14]
                                         idx_reg[arb.gnt_ch],
                                         con_reg[arb.gnt_ch][CON_SIZE],
                                         con_reg[arb.gnt_ch][CON_AM_LSB+:2]); // [R10]
            XFER_PERIPH_ADDR <= pad_reg[arb.gnt_ch];
            XFER_BYTE        <= con_reg[arb.gnt_ch][CON_SIZE]; // [R06]
            XFER_RAM_TO_PERIPH <= con_reg[arb.gnt_ch][CON_DIR]; // [R07]
            // Null write only meaningful with peripheral-to-RAM direction
            XFER_NULL_WRITE  <= con_reg[arb.gnt_ch][CON_NULL_PERIPHERAL_WRITE] &
                                ~con_reg[arb.gnt_ch][CON_DIR]; // [R09]
            XFER_PERIPH_INDIRECT <= con_reg[arb.gnt_ch][CON_AM_LSB+:2]
                                    == AM_PIA; // [R10]
            lca_reg          <= {2'h0, arb.gnt_ch}; // [R03]
            state_reg        <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (XFER_DONE) begin
            XFER_VALID <= 1'b0;
            ladr_reg   <= XFER_RAM_ADDR; // [R03]
            state_reg  <= ST_IDLE;
            if (blk_last) begin
              idx_reg[cur_reg] <= RST_CNT; // [R18]
              if (ccur[CON_MD_LSB+1]) begin
                ppst_reg[cur_reg] <= ~ppst_reg[cur_reg]; // [R14]
              end
            end else begin
              idx_reg[cur_reg] <= idx_reg[cur_reg] + 14'h1;
            end
          end
        end
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (arm[c]) begin
          idx_reg[c]  <= RST_CNT;
          ppst_reg[c] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status and interrupts
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pwc_reg <= 4'h0;
    end else if (CLK_EN) begin
      for (int c = 0; c < NCH; c++) begin
        if (done_ev && XFER_WCOL && cur_reg == 2'(c)) begin
          pwc_reg[c] <= 1'b1; // [R03]
        end else if (wr_stb && a == OFS_PWC && WB_SEL_I[0] && WB_DAT_I[c]) begin
          pwc_reg[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      imask_reg <= 8'h00;
    end else if (CLK_EN && wr_stb && a == OFS_IMASK && WB_SEL_I[0]) begin
      imask_reg <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      istat_reg <= 8'h00;
      CH_IRQ    <= 4'h0;
      IRQ       <= 1'b0;
    end else if (CLK_EN) begin
      // Read clears, but an event in the same cycle survives
      istat_reg <= ((rd_stb && a == OFS_ISTAT) ? 8'h00 : istat_reg) |
                   {set_req & pend_reg & ~clr_req, chan_ev};
      // One-cycle event per channel toward the interrupt controller
      CH_IRQ    <= chan_ev; // [R04] [R16]
      IRQ       <= |(istat_reg & imask_reg);
    end
  end

endmodule
`default_nettype wire

// ---- testbench/dcc_sva.sv ----
// Port-level assertions for the DMA channel control block
`timescale 1ns/10ps
`default_nettype none
module dcc_sva (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        CLK_EN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        XFER_VALID,
  input wire logic        XFER_DONE,
  input wire logic [1:0]  XFER_CHANNEL,
  input wire logic [31:0] XFER_RAM_ADDR,
  input wire logic        XFER_RAM_TO_PERIPH,
  input wire logic        XFER_NULL_WRITE,
  input wire logic [3:0]  CH_IRQ,
  input wire logic        IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // ----------------
  // Register bus
  // ----------------
  a_ack_pulse: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (CLK_EN && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered next cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("ack without a request");
  a_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  // ----------------
  // Transfer port and events
  // ----------------
  a_xfer_stand: assert property (XFER_VALID && !XFER_DONE |=> XFER_VALID && $stable(XFER_RAM_ADDR) && $stable(XFER_CHANNEL))
    else $error("transfer changed before done");
  a_xfer_end: assert property (XFER_VALID && XFER_DONE && CLK_EN |=> !XFER_VALID)
    else $error("transfer not ended after done");
  a_null_dir: assert property (XFER_VALID && XFER_NULL_WRITE |-> !XFER_RAM_TO_PERIPH)
    else $error("null write with ram-to-peripheral direction");
  a_event_cause: assert property (CH_IRQ != 4'h0 |-> $past(XFER_VALID) && $past(XFER_DONE) && CH_IRQ == (4'h1 << $past(XFER_CHANNEL)))
    else $error("channel event without finished transfer");
  a_event_pulse: assert property (CH_IRQ != 4'h0 && CLK_EN |=> CH_IRQ == 4'h0)
    else $error("channel event longer than one cycle");
  c_bus: cover property (WB_ACK_O);
  c_done: cover property (XFER_VALID && XFER_DONE);
  c_event: cover property (CH_IRQ != 4'h0);
  c_irq: cover property (IRQ);
endmodule
bind dcc_top dcc_sva u_sva (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
  .XFER_VALID(XFER_VALID), .XFER_DONE(XFER_DONE), .XFER_CHANNEL(XFER_CHANNEL),
  .XFER_RAM_ADDR(XFER_RAM_ADDR), .XFER_RAM_TO_PERIPH(XFER_RAM_TO_PERIPH),
  .XFER_NULL_WRITE(XFER_NULL_WRITE), .CH_IRQ(CH_IRQ), .IRQ(IRQ));
`default_nettype wire

// ---- testbench/dcc_xfer_model.sv ----
// Far-side responder: peripherals and RAM bus finishing each transfer
`timescale 1ns/10ps
`default_nettype none
module dcc_xfer_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       valid,
  input  wire logic [3:0] lat,
  input  wire logic       wcol_on,
  output var  logic       done,
  output var  logic       wcol
);
  logic [3:0] wait_reg;
  always_ff @(posedge clk) begin
    if (rst || !valid || done) begin
      wait_reg <= 4'h0;
      done     <= 1'b0;
    end else if (wait_reg == lat) begin
      done <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // Meaningless outside done, so it toggles to expose stale sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      wcol <= 1'b0;
    end else begin
      wcol <= (valid && !done && wait_reg == lat) ? wcol_on : ~wcol;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the DMA channel control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dcc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rq = 1'b0, ce = 1'b1;
  logic        xv, xr2p, xby, xnw, xpi, xdn, xwc, ack, irq, wc_on = 1'b0;
  logic [1:0]  xch;
  logic [3:0]  sel = 4'h0, lat = 4'h1, chirq;
  logic [7:0]  adr = 8'h00, src = 8'h00;
  logic [15:0] xpa;
  logic [31:0] dw = 32'h0, dr, xra;
  int          fail_count = 0, num_checks = 0, cyc_n = 0;

  always #50 clk = ~clk;

  dcc_top DUT (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .REQ_STROBE(rq), .REQ_SOURCE(src), .XFER_VALID(xv), .XFER_CHANNEL(xch), .XFER_RAM_ADDR(xra),
    .XFER_PERIPH_ADDR(xpa), .XFER_RAM_TO_PERIPH(xr2p), .XFER_BYTE(xby), .XFER_NULL_WRITE(xnw),
    .XFER_PERIPH_INDIRECT(xpi), .XFER_DONE(xdn), .XFER_WCOL(xwc), .CH_IRQ(chirq), .IRQ(irq));
  dcc_xfer_model u_far (.clk(clk), .rst(rst), .valid(xv), .lat(lat), .wcol_on(wc_on),
    .done(xdn), .wcol(xwc));

  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ra(input logic [1:0] c, input logic [4:0] o);
    return {1'b0, c, o};
  endfunction
  // Request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [15:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dw <= {16'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dr[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 16'h0, q);
    chk(q, e);
  endtask
  task automatic kick(input logic [7:0] s);
    src <= s;
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
  endtask
  task automatic xfer(input logic [1:0] c, input logic [31:0] a, input logic [3:0] f,
                      input logic ev);
    do begin
      @(negedge clk);
    end while (xv !== 1'b1);
    chk({xch, xr2p, xby, xnw, xpi, xpa, xra}, {c, f, 16'h0a40 + c, a});
    while (xv !== 1'b0) begin
      @(negedge clk);
    end
    chk(chirq, ev ? 4'h1 << c : 4'h0);
    @(posedge clk);
  endtask
  task automatic prog(input logic [1:0] c, input logic [15:0] con, input logic [13:0] cnt,
                      input logic [15:0] sa, input logic [15:0] sb, input logic [7:0] s);
    wr(ra(c, OFS_CON), 16'h0);
    wr(ra(c, OFS_REQ), {8'h0, s});
    wr(ra(c, OFS_STAL), sa);
    wr(ra(c, OFS_STAH), 16'h0001);
    wr(ra(c, OFS_STBL), sb);
    wr(ra(c, OFS_STBH), 16'h0002);
    wr(ra(c, OFS_PAD), 16'h0a40 + c);
    wr(ra(c, OFS_CNT), {2'h0, cnt});
    wr(ra(c, OFS_CON), con);
  endtask
  task automatic blk(input logic [1:0] c, input logic [15:0] con, input logic [13:0] cnt,
                     input logic [31:0] base, input logic [7:0] s);
    logic [31:0] a;
    logic        ev;
    for (int i = 0; i <= cnt; i++) begin
      a = (con[5:4] == 2'h0) ? base + (con[14] ? i : 2 * i) : base;
      ev = con[12] ? (i == cnt >> 1) : (i == cnt);
      kick(s);
      xfer(c, a, {con[13], con[14], con[11], con[5:4] == 2'h2}, ev);
    end
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic s_regs;
    rdc(OFS_LCA, 16'h000f);
    for (int c = 0; c < 4; c++) begin
      rdc(ra(c[1:0], OFS_CON), 16'h0000);
      wr(ra(c[1:0], OFS_REQ), 16'hab10 + c[15:0]);
      wr(ra(c[1:0], OFS_CNT), 16'hffff);
      wr(ra(c[1:0], OFS_CON), 16'hffff);
    end
    for (int c = 0; c < 4; c++) begin
      rdc(ra(c[1:0], OFS_REQ), 16'h0010 + c[15:0]);
      rdc(ra(c[1:0], OFS_CNT), 16'h3fff);
      rdc(ra(c[1:0], OFS_CON), 16'hf833);
      wr(ra(c[1:0], OFS_CON), 16'h0000);
    end
    rdc(8'hfc, 16'h0000);
  endtask
  task automatic s_modes;
    logic [15:0] cm [4] = '{16'h8000, 16'hd000, 16'ha010, 16'h8820};
    for (int c = 0; c < 4; c++) begin
      prog(c[1:0], cm[c], 14'h3, {c[7:0], 8'h40}, 16'h0, 8'h20 + c[7:0]);
      blk(c[1:0], cm[c], 14'h3, {16'h0001, c[7:0], 8'h40}, 8'h20 + c[7:0]);
      wr(ra(c[1:0], OFS_CON), 16'h0);
    end
    rdc(OFS_LCA, 16'h0003);
    quiet(8'h23);
  endtask
  task automatic s_ping;
    prog(2'h1, 16'h8002, 14'h1, 16'h0200, 16'h0300, 8'h31);
    blk(2'h1, 16'h8002, 14'h1, 32'h0001_0200, 8'h31);
    blk(2'h1, 16'h8002, 14'h1, 32'h0002_0300, 8'h31);
    blk(2'h1, 16'h8002, 14'h1, 32'h0001_0200, 8'h31);
    rdc(OFS_PPS, 16'h0002);
    rdc(OFS_ADRL, 16'h0202);
    ce <= 1'b0;
    kick(8'h31);
    ce <= 1'b1;
    quiet(8'h00);
    wr(ra(2'h1, OFS_CON), 16'h0);
  endtask
  // Two channels pending, one repeat request
  task automatic s_prio;
    logic [15:0] q;
    wb(1'b0, OFS_ISTAT, 16'h0, q);
    lat <= 4'ha;
    wc_on <= 1'b1;
    wr(OFS_IMASK, 16'h0001);
    prog(2'h0, 16'h8000, 14'h0, 16'h0900, 16'h0, 8'h60);
    prog(2'h3, 16'h8000, 14'h0, 16'h0a00, 16'h0, 8'h63);
    wr(OFS_MANUAL, 16'h0009);
    wr(OFS_MANUAL, 16'h0008);
    xfer(2'h0, 32'h0001_0900, 4'h0, 1'b1);
    xfer(2'h3, 32'h0001_0a00, 4'h0, 1'b1);
    chk(irq, 1'b1);
    rdc(OFS_ISTAT, 16'h0089);
    rdc(OFS_ISTAT, 16'h0000);
    chk(irq, 1'b0);
    rdc(OFS_RQC, 16'h0008);
    rdc(OFS_PWC, 16'h0009);
    wr(OFS_PWC, 16'h0009);
    wr(OFS_RQC, 16'h0008);
    rdc(OFS_PWC, 16'h0000);
    rdc(OFS_RQC, 16'h0000);
    wr(OFS_IMASK, 16'h0000);
    wr(ra(2'h0, OFS_CON), 16'h0);
    wr(ra(2'h3, OFS_CON), 16'h0);
    wc_on <= 1'b0;
    lat <= 4'h1;
  endtask
  task automatic quiet(input logic [7:0] s);
    int hits;
    hits = 0;
    kick(s);
    repeat (10) begin
      @(negedge clk);
      if (xv === 1'b1) hits++;
    end
    chk(hits, 0);
    @(posedge clk);
  endtask
  task automatic s_oneshot;
    prog(2'h2, 16'h8001, 14'h0, 16'h0500, 16'h0600, 8'h42);
    blk(2'h2, 16'h8001, 14'h0, 32'h0001_0500, 8'h42);
    rdc(ra(2'h2, OFS_CON), 16'h0001);
    quiet(8'h42);
    chk(irq, 1'b0);
    prog(2'h3, 16'h8003, 14'h0, 16'h0700, 16'h0800, 8'h53);
    blk(2'h3, 16'h8003, 14'h0, 32'h0001_0700, 8'h53);
    blk(2'h3, 16'h8003, 14'h0, 32'h0002_0800, 8'h53);
    rdc(ra(2'h3, OFS_CON), 16'h0003);
    quiet(8'h53);
  endtask

  // ----------------
  // Sequence and verdict
  // ----------------
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_modes();
    s_ping();
    s_prio();
    s_oneshot();
    report_and_stop();
  end
  // Whole run needs under a thousand cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
